// [rtl/oxe_pkg.sv]
// constants and types shared by the or-shift-jump execution unit
package oxe_pkg;
  // register byte offsets on the avalon slave
  localparam logic [7:0] OFS_CMD     = 8'h00;
  localparam logic [7:0] OFS_ACC     = 8'h04;
  localparam logic [7:0] OFS_FLAGS   = 8'h08;
  localparam logic [7:0] OFS_PC      = 8'h0C;
  localparam logic [7:0] OFS_LATCH   = 8'h10;
  localparam logic [7:0] OFS_RF_IDX  = 8'h14;
  localparam logic [7:0] OFS_RF_DATA = 8'h18;

  // command word fields
  localparam int CMD_OPD_LSB  = 0;
  localparam int CMD_OPD_W    = 11;
  localparam int CMD_DEST_BIT = 15;
  localparam int CMD_OP_LSB   = 16;
  localparam int CMD_OP_W     = 3;

  // flags register fields
  localparam int FLG_CARRY = 0;
  localparam int FLG_ZERO  = 1;
  localparam int FLG_BUSY  = 2;

  // widths and field positions of the datapath
  localparam int DATA_W     = 8;
  localparam int IDX_W      = 7;
  localparam int PC_W       = 15;
  localparam int PC_LOW_W   = 11;
  localparam int LATCH_W    = 7;
  localparam int LATCH_JLSB = 3;
  localparam int LATCH_JMSB = 6;

  // reset values
  localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
  localparam logic [PC_W-1:0]    PC_RST    = 15'h0000;
  localparam logic [LATCH_W-1:0] LATCH_RST = 7'h00;

  // destination bit encodings
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_REG = 1'b1;

  typedef enum logic [CMD_OP_W-1:0] {
    OP_JUMP = 3'h0,
    OP_ORL  = 3'h1,
    OP_INC  = 3'h2,
    OP_ORW  = 3'h3,
    OP_SHL  = 3'h4,
    OP_SHR  = 3'h5
  } oxe_op_t;

  typedef enum logic [0:0] {
    ST_IDLE     = 1'b0,
    ST_JUMP_TWO = 1'b1
  } oxe_state_t;
endpackage

// [rtl/oxe_exec.sv]
// execution unit for jump, or, increment and logical shifts behind an avalon slave
//
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/1ps

// Operation
// - jump loads 11-bit operand into pc low bits
// - pc bits 14:11 come from latch 6:3
// - jump takes two cycles, flags untouched
// - or literal into accumulator, zero only
// - increment register, destination bit picks target
// - or accumulator with register, zero only
// - left shift: bit7 to carry, zero in
// - right shift: bit0 to carry, zero in
// - shift result to accumulator or register
module oxe_exec
  import oxe_pkg::*;
#(
  parameter int RF_DEPTH = 128
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // avalon-mm slave
  input  wire logic [7:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [3:0]  byteenable_i,
  input  wire logic [31:0] writedata_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o
);

  // the index field addresses exactly this many entries
  if (RF_DEPTH != (1 << IDX_W)) begin : g_depth_chk
    $error("RF_DEPTH must equal 2**IDX_W");
  end

  logic [DATA_W-1:0]  rf_mem [RF_DEPTH];
  logic [DATA_W-1:0]  acc_ff;
  logic [PC_W-1:0]    pc_ff;
  logic [LATCH_W-1:0] latch_ff;
  logic [IDX_W-1:0]   rf_idx_ff;
  logic               carry_ff;
  logic               zero_ff;
  logic               ack_ff;
  logic [31:0]        rdata_ff;
  oxe_state_t         state_ff;

  // bus decode
  wire        req       = read_i | write_i;
  wire        busy      = (state_ff == ST_JUMP_TWO);
  // every access waits one cycle; any access also waits out a jump in flight
  wire        take      = req & ack_ff & ~busy;
  wire        wr_take   = take & write_i;
  wire        full_word = (byteenable_i == 4'hF);
  wire        sel_cmd   = (address_i == OFS_CMD);
  wire        sel_acc   = (address_i == OFS_ACC);
  wire        sel_flags = (address_i == OFS_FLAGS);
  wire        sel_pc    = (address_i == OFS_PC);
  wire        sel_latch = (address_i == OFS_LATCH);
  wire        sel_idx   = (address_i == OFS_RF_IDX);
  wire        sel_data  = (address_i == OFS_RF_DATA);
  wire        issue     = wr_take & sel_cmd & full_word;
  wire        wr_acc    = wr_take & sel_acc & byteenable_i[0];
  wire        wr_latch  = wr_take & sel_latch & byteenable_i[0];
  wire        wr_idx    = wr_take & sel_idx & byteenable_i[0];
  wire        wr_data   = wr_take & sel_data & byteenable_i[0];

  // command fields
  wire [CMD_OP_W-1:0]  cmd_op   = writedata_i[CMD_OP_LSB +: CMD_OP_W];
  wire                 cmd_dest = writedata_i[CMD_DEST_BIT];
  wire [CMD_OPD_W-1:0] cmd_opd  = writedata_i[CMD_OPD_LSB +: CMD_OPD_W];
  wire [IDX_W-1:0]     cmd_idx  = cmd_opd[IDX_W-1:0];
  wire [DATA_W-1:0]    cmd_lit  = cmd_opd[DATA_W-1:0];
  wire [DATA_W-1:0]    operand  = rf_mem[cmd_idx];

  // datapath
  logic [DATA_W-1:0] result;
  logic              res_valid;
  logic              res_to_reg;
  logic              carry_upd;
  logic              nxt_carry;
  logic              is_jump;

  always_comb begin
    result     = '0;
    res_valid  = 1'b0;
    res_to_reg = 1'b0;
    carry_upd  = 1'b0;
    nxt_carry  = carry_ff;
    is_jump    = 1'b0;
    unique case (cmd_op)
      OP_JUMP: begin
        is_jump = 1'b1;
      end
      OP_ORL: begin
        result    = acc_ff | cmd_lit;
        res_valid = 1'b1;
      end
      OP_INC: begin
        result     = operand + 8'h01;
        res_valid  = 1'b1;
        res_to_reg = (cmd_dest == DEST_REG);
      end
      OP_ORW: begin
        result     = acc_ff | operand;
        res_valid  = 1'b1;
        res_to_reg = (cmd_dest == DEST_REG);
      end
      OP_SHL: begin
        result     = {operand[DATA_W-2:0], 1'b0};
        nxt_carry  = operand[DATA_W-1];
        carry_upd  = 1'b1;
        res_valid  = 1'b1;
        res_to_reg = (cmd_dest == DEST_REG);
      end
      OP_SHR: begin
        result     = {1'b0, operand[DATA_W-1:1]};
        nxt_carry  = operand[0];
        carry_upd  = 1'b1;
        res_valid  = 1'b1;
        res_to_reg = (cmd_dest == DEST_REG);
      end
      // undefined opcodes are dropped without side effects
      default: begin
        res_valid = 1'b0;
      end
    endcase
  end

  wire              do_exec  = issue & res_valid;
  wire              do_jump  = issue & is_jump;
  wire              nxt_zero = (result == '0);
  wire [PC_W-1:0]   nxt_pc   = {latch_ff[LATCH_JMSB:LATCH_JLSB], cmd_opd};
  wire              acc_load = (do_exec & ~res_to_reg) | wr_acc;
  wire [DATA_W-1:0] nxt_acc  = wr_acc ? writedata_i[DATA_W-1:0] : result;

  // read mux, unmapped offsets read as zero
  wire [31:0] flags_word = {29'h0, busy, zero_ff, carry_ff};
  wire [31:0] rd_mux =
      sel_acc   ? {24'h0, acc_ff} :
      sel_flags ? flags_word :
      sel_pc    ? {17'h0, pc_ff} :
      sel_latch ? {25'h0, latch_ff} :
      sel_idx   ? {25'h0, rf_idx_ff} :
      sel_data  ? {24'h0, rf_mem[rf_idx_ff]} :
      32'h0;

  assign waitrequest_o = req & ~take;
  assign readdata_o    = rdata_ff;

  // handshake and read data
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      // no ack during the jump's second cycle, else that cycle is invisible on the bus
      ack_ff   <= req & ~take & ~busy;
      rdata_ff <= rd_mux;
    end
  end

  // jump occupies a second cycle before the next access is taken
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE:     state_ff <= do_jump ? ST_JUMP_TWO : ST_IDLE;
        ST_JUMP_TWO: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_ff <= PC_RST;
    end else if (do_jump) begin
      pc_ff <= nxt_pc;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_ff <= ACC_RST;
    end else if (acc_load) begin
      acc_ff <= nxt_acc;
    end
  end

  // flags change only on executed alu ops, never on a jump
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      carry_ff <= 1'b0;
      zero_ff  <= 1'b0;
    end else if (do_exec) begin
      zero_ff <= nxt_zero;
      if (carry_upd) begin
        carry_ff <= nxt_carry;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_ff  <= LATCH_RST;
      rf_idx_ff <= '0;
    end else begin
      if (wr_latch) begin
        latch_ff <= writedata_i[LATCH_W-1:0];
      end
      if (wr_idx) begin
        rf_idx_ff <= writedata_i[IDX_W-1:0];
      end
    end
  end

  // register file has no reset, as real file registers power up undefined
  always_ff @(posedge core_clk_i) begin
    if (do_exec & res_to_reg) begin
      rf_mem[cmd_idx] <= result;
    end else if (wr_data) begin
      rf_mem[rf_idx_ff] <= writedata_i[DATA_W-1:0];
    end
  end

endmodule

// [test/oxe_exec_properties.sv]
// bus timing and read width checks for the execution unit
`timescale 1ns/1ps
module oxe_exec_properties
  import oxe_pkg::*;
(
  // watched ports
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  address_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [3:0]  byteenable_i,
  input wire logic [31:0] writedata_i,
  input wire logic [31:0] readdata_o,
  input wire logic        waitrequest_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  wire req = read_i | write_i;
  wire rt  = read_i & ~waitrequest_o;
  wire jt  = write_i & ~waitrequest_o & address_i == OFS_CMD & byteenable_i == 4'hF & writedata_i[18:16] == 3'h0;
  idle_ready_a: assert property (!req |-> !waitrequest_o) else $error("wait while idle");
  first_wait_a: assert property ($rose(req) |-> waitrequest_o) else $error("no first wait");
  wait_bound_a: assert property ((req && waitrequest_o) [*2] |=> !waitrequest_o) else $error("wait too long");
  jump_stall_a: assert property (jt ##1 req |-> waitrequest_o [*2]) else $error("jump stall short");
  cmd_zero_a: assert property (rt && address_i == OFS_CMD |-> readdata_o == 32'h0) else $error("cmd read");
  acc_width_a: assert property (rt && address_i == OFS_ACC |-> readdata_o[31:8] == 24'h0) else $error("acc");
  pc_width_a: assert property (rt && address_i == OFS_PC |-> readdata_o[31:15] == 17'h0) else $error("pc");
  flag_width_a: assert property (rt && address_i == OFS_FLAGS |-> readdata_o[31:2] == 30'h0) else $error("flags");
endmodule
bind oxe_exec oxe_exec_properties u_props (.core_clk_i, .rst_i, .address_i, .read_i, .write_i, .byteenable_i,
  .writedata_i, .readdata_o, .waitrequest_o);

// [test/testbench.sv]
// random self-checking bench for the execution unit
`timescale 1ns/1ps
module testbench
  import oxe_pkg::*;
;
  logic        core_clk_i = 1'b0, rst_i = 1'b1, read_i = 1'b0, write_i = 1'b0, waitrequest_o;
  logic [7:0]  address_i = 8'h00, acc = 8'h00, a, rf [128];
  logic [3:0]  byteenable_i = 4'hF;
  logic [31:0] writedata_i = 32'h0, readdata_o;
  logic [14:0] pc = 15'h0;
  logic [6:0]  lat = 7'h00;
  logic [1:0]  fl = 2'h0;
  int          error_cnt = 0, checks = 0, cyc = 0;
  logic [7:0]  ofs [7] = '{OFS_CMD, OFS_ACC, OFS_FLAGS, OFS_PC, OFS_LATCH, OFS_RF_IDX, 8'h1C};
  oxe_exec uut (.core_clk_i, .rst_i, .address_i, .read_i, .write_i, .byteenable_i, .writedata_i, .readdata_o,
    .waitrequest_o);
  always #12.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] a, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] reg %h expected %h seen %h", a, exp, seen);
    end
  endtask
  // reference alu op: {carry, result}; ops without carry pass c through
  function automatic logic [8:0] alu_ref(input logic [2:0] op, input logic [7:0] w, r, k, input logic c);
    case (op)
      3'h1: alu_ref = {c, w | k};
      3'h2: alu_ref = {c, r + 8'h01};
      3'h3: alu_ref = {c, w | r};
      3'h4: alu_ref = {r, 1'b0};
      3'h5: alu_ref = {r[0], 1'b0, r[7:1]};
      default: alu_ref = {c, r};
    endcase
  endfunction
  // request stands until waitrequest is sampled low; reads compare against d
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
    read_i <= ~w;
    write_i <= w;
    address_i <= a;
    writedata_i <= d;
    byteenable_i <= be;
    @(posedge core_clk_i);
    while (waitrequest_o) @(posedge core_clk_i);
    if (!w) check(a, readdata_o, d);
  endtask
  task automatic exec(input logic [2:0] op, input logic dst, input logic [10:0] k);
    logic [6:0] i;
    logic [7:0] r;
    logic       c;
    i = k[6:0];
    bus(1'b1, OFS_CMD, {13'h0, op, dst, 4'h0, k});
    {c, r} = alu_ref(op, acc, rf[i], k[7:0], fl[0]);
    if (op == 3'h0) pc = {lat[6:3], k};
    if (op inside {[3'h1:3'h5]}) begin
      fl = {r == 8'h00, c};
      if (dst && op != 3'h1) rf[i] = r;
      else acc = r;
    end
    bus(1'b0, OFS_ACC, {24'h0, acc});
    bus(1'b0, OFS_FLAGS, {30'h0, fl});
    bus(1'b0, OFS_PC, {17'h0, pc});
    bus(1'b1, OFS_RF_IDX, {25'h0, i});
    bus(1'b0, OFS_RF_DATA, {24'h0, rf[i]});
  endtask
  initial begin
    void'($urandom(32'h5F7E));
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    foreach (ofs[j]) bus(1'b0, ofs[j], 32'h0);
    for (int j = 0; j < 128; j++) begin
      a = j == 127 ? 8'hFF : j == 0 ? 8'h80 : j == 1 ? 8'h01 : 8'($urandom);
      bus(1'b1, OFS_RF_IDX, 32'(j));
      bus(1'b1, OFS_RF_DATA, {24'h0, a});
      rf[j] = a;
    end
    bus(1'b1, OFS_LATCH, 32'h60);
    lat = 7'h60;
    exec(3'h0, 1'b0, 11'h7FF);
    exec(3'h2, 1'b1, 11'h07F);
    exec(3'h4, 1'b0, 11'h000);
    exec(3'h1, 1'b0, 11'h000);
    exec(3'h5, 1'b1, 11'h001);
    // partial command write must leave the accumulator alone
    bus(1'b1, OFS_CMD, 32'h100A5, 4'h7);
    bus(1'b0, OFS_ACC, {24'h0, acc});
    repeat (80) begin
      a = 8'($urandom);
      bus(1'b1, OFS_LATCH, {24'h0, a});
      lat = a[6:0];
      exec(3'($urandom), a[0], 11'($urandom));
    end
    read_i <= 1'b0;
    write_i <= 1'b0;
    @(posedge core_clk_i);
    give_verdict();
  end
endmodule
